// ---- core/uarx_baud.sv ----
// timer 2 as baud generator: prescaled up counter with reload
`timescale 1ns/1ps
`include "uarx_consts.svh"
module uarx_baud (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [1:0] prescale_sel,
	input wire logic [15:0] reload,
	output logic t2_ovf
);
	import uarx_pkg::*;
	logic [5:0] pre;
	logic [5:0] pre_tc;
	logic [15:0] cnt;
	// reserved select code 11 falls back to the slowest rate
	always_comb
	begin
		case (prescale_sel)
			2'h0: pre_tc = `UX_PRE4_TC;
			2'h1: pre_tc = `UX_PRE16_TC;
			default: pre_tc = `UX_PRE64_TC;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pre <= 6'h00;
			cnt <= `UX_RST16;
			t2_ovf <= 1'b0;
		end
		else if (!run)
		begin
			// a stopped timer restarts from the reload value, so the first bit is not late
			pre <= 6'h00;
			cnt <= reload;
			t2_ovf <= 1'b0;
		end
		else
		begin
			t2_ovf <= 1'b0;
			if (pre >= pre_tc)
			begin
				pre <= 6'h00;
				if (cnt == `UX_T2_MAX)
				begin
					cnt <= reload;
					t2_ovf <= 1'b1;
				end
				else
					cnt <= cnt + 16'h0001;
			end
			else
				pre <= pre + 6'h01;
		end
	end
endmodule

// ---- core/uarx_consts.svh ----
// register map, field positions and counts for the serial port block
`ifndef UARX_CONSTS_SVH
`define UARX_CONSTS_SVH
`define UX_OFS_T2CTL 12'h418
`define UX_OFS_T2RLD 12'h41C
`define UX_OFS_SCTL 12'h420
`define UX_OFS_STAT 12'h424
`define UX_OFS_BUF 12'h428
`define UX_OFS_ADDR 12'h42C
`define UX_OFS_MASK 12'h430
`define UX_OFS_PRE 12'h440
`define UX_B_RCLK 5
`define UX_B_TCLK 4
`define UX_B_PRE_HI 3
`define UX_B_PRE_LO 2
`define UX_B_SM2 5
`define UX_B_REN 4
`define UX_B_TB8 3
`define UX_B_RB8 2
`define UX_B_TI 1
`define UX_B_RI 0
`define UX_B_FE 3
`define UX_B_BR 2
`define UX_B_OE 1
`define UX_B_STINT 0
`define UX_RST8 8'h00
`define UX_RST16 16'h0000
`define UX_PRE4_TC 6'h03
`define UX_PRE16_TC 6'h0F
`define UX_PRE64_TC 6'h3F
`define UX_T2_MAX 16'hFFFF
`define UX_OS_LAST 4'hF
`define UX_OS_CENTRE 4'h7
`define UX_M0_SAMPLE 4'h8
`define UX_LAST_M0 4'h7
`define UX_LAST_M1 4'h9
`define UX_LAST_M23 4'hA
`define UX_OVR_M0 4'h7
`define UX_OVR_M123 4'h8
`define UX_RESP_OK 2'h0
`define UX_RESP_ERR 2'h2
`endif

// ---- core/uarx_pkg.sv ----
// types shared by the serial port block
package uarx_pkg;
	typedef enum logic {UX_TX_IDLE, UX_TX_SHIFT} uarx_tx_st_t;
	typedef enum logic {UX_RX_IDLE, UX_RX_FRAME} uarx_rx_st_t;
	typedef logic [1:0] uarx_mode_t;
endpackage

// ---- core/uarx_top.sv ----
// serial port with error status, multiprocessor filter and address match
//
// Summary of operation
// - timer2 control bits pick timer 2 overflow for transmitter and/or receiver
// - timer 2 as baud source counts at oscillator over 4, 16 or 64
// - in baud use the timer 2 external pin becomes an extra interrupt
// - framing flag sets on missing stop bit, sticky until software clears
// - break flag sets when all bits including stop are zero
// - overrun flag sets when bit 8 arrives while receive flag still set
// - status flags reach the receive interrupt only with the gate bit set
// - receive and transmit raise separate interrupt requests
// - modes 2 and 3 store the received ninth bit
// - with multiprocessor enable, 9-bit modes flag only ninth bit one
// - mode 1 with multiprocessor enable flags only on valid stop bit
// - multiprocessor enable does nothing in mode 0
// - 9-bit modes with enable flag on given or broadcast address match
// - given address is address gated by mask, zero mask bits ignored
// - broadcast address is address OR mask, zeros ignored
// - reset clears slave address and mask, so any address matches
// - mode 0 shift at osc/16, 1 8-bit, 2 9-bit osc/32, 3 9-bit variable
// - transmitted ninth bit is read from control when it is sent
// - transmit flag sets at byte end and on write to idle transmitter
// - mode 1 frame is start, eight data bits lsb first, stop
// - reception starts only with receive enable; mode 0 also needs flag clear
`timescale 1ns/1ps
`include "uarx_consts.svh"
module uarx_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd,
	input wire logic timer1_ovf,
	input wire logic timer2_ext_pin,
	output logic ext_int2,
	output logic rx_irq,
	output logic tx_irq
);
	import uarx_pkg::*;
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic known(input logic [11:0] a);
		known = a == `UX_OFS_T2CTL || a == `UX_OFS_T2RLD || a == `UX_OFS_SCTL ||
			a == `UX_OFS_STAT || a == `UX_OFS_BUF || a == `UX_OFS_ADDR ||
			a == `UX_OFS_MASK || a == `UX_OFS_PRE;
	endfunction
	function automatic logic baud_tick(input uarx_mode_t md, input logic use_t2,
		input logic t2o, input logic t1o, input logic half);
		case (md)
			2'h0: baud_tick = 1'b1;
			2'h2: baud_tick = half;
			default: baud_tick = use_t2 ? t2o : t1o;
		endcase
	endfunction
	function automatic logic [3:0] last_bit(input uarx_mode_t md);
		case (md)
			2'h0: last_bit = `UX_LAST_M0;
			2'h1: last_bit = `UX_LAST_M1;
			default: last_bit = `UX_LAST_M23;
		endcase
	endfunction
	function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] a,
		input logic [7:0] m);
		addr_hit = (((b ^ a) & m) == 8'h00) || ((~b & (a | m)) == 8'h00);
	endfunction
	// ****************************************
	// registers and bus slave
	// ****************************************
	logic [7:0] t2_ctrl, pre_cfg, ser_ctrl, ext_stat, slave_address, slave_address_mask;
	logic [7:0] rx_buf, tx_data;
	logic [15:0] t2_reload;
	logic aw_held, w_held, wr_en;
	logic [11:0] wa;
	logic [7:0] wd0, wd1;
	logic [1:0] ws;
	uarx_mode_t mode;
	logic sm2, ren, ri, ti, stint, half, t2_ovf, t2_run, sc_wr, st_wr;
	assign mode = ser_ctrl[7:6];
	assign sm2 = ser_ctrl[`UX_B_SM2];
	assign ren = ser_ctrl[`UX_B_REN];
	assign ri = ser_ctrl[`UX_B_RI];
	assign ti = ser_ctrl[`UX_B_TI];
	assign stint = ext_stat[`UX_B_STINT];
	assign t2_run = t2_ctrl[`UX_B_RCLK] | t2_ctrl[`UX_B_TCLK];
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	assign wr_en = aw_held && w_held && !bvalid;
	assign sc_wr = wr_en && wa == `UX_OFS_SCTL && ws[0];
	assign st_wr = wr_en && wa == `UX_OFS_STAT && ws[0];
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wa <= 12'h000;
			wd0 <= `UX_RST8;
			wd1 <= `UX_RST8;
			ws <= 2'h0;
			bvalid <= 1'b0;
			bresp <= `UX_RESP_OK;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				wa <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				wd0 <= wdata[7:0];
				wd1 <= wdata[15:8];
				ws <= wstrb[1:0];
			end
			if (wr_en)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= known(wa) ? `UX_RESP_OK : `UX_RESP_ERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `UX_RESP_OK;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rresp <= known(araddr) ? `UX_RESP_OK : `UX_RESP_ERR;
			case (araddr)
				`UX_OFS_T2CTL: rdata <= {24'h00_0000, t2_ctrl};
				`UX_OFS_T2RLD: rdata <= {16'h0000, t2_reload};
				`UX_OFS_SCTL: rdata <= {24'h00_0000, ser_ctrl};
				`UX_OFS_STAT: rdata <= {24'h00_0000, ext_stat};
				`UX_OFS_BUF: rdata <= {24'h00_0000, rx_buf};
				`UX_OFS_ADDR: rdata <= {24'h00_0000, slave_address};
				`UX_OFS_MASK: rdata <= {24'h00_0000, slave_address_mask};
				`UX_OFS_PRE: rdata <= {24'h00_0000, pre_cfg};
				default: rdata <= 32'h0000_0000;
			endcase
		end
		else if (rready)
			rvalid <= 1'b0;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			t2_ctrl <= `UX_RST8;
			pre_cfg <= `UX_RST8;
			t2_reload <= `UX_RST16;
			slave_address <= `UX_RST8;
			slave_address_mask <= `UX_RST8;
		end
		else if (wr_en)
		begin
			if (wa == `UX_OFS_T2CTL && ws[0])
				t2_ctrl <= wd0;
			if (wa == `UX_OFS_PRE && ws[0])
				pre_cfg <= wd0;
			if (wa == `UX_OFS_T2RLD && ws[0])
				t2_reload[7:0] <= wd0;
			if (wa == `UX_OFS_T2RLD && ws[1])
				t2_reload[15:8] <= wd1;
			if (wa == `UX_OFS_ADDR && ws[0])
				slave_address <= wd0;
			if (wa == `UX_OFS_MASK && ws[0])
				slave_address_mask <= wd0;
		end
	end
	// ****************************************
	// baud sources
	// ****************************************
	uarx_baud u_baud (
		.clk(clk),
		.rst_b(rst_b),
		.run(t2_run),
		.prescale_sel({pre_cfg[`UX_B_PRE_HI], pre_cfg[`UX_B_PRE_LO]}),
		.reload(t2_reload),
		.t2_ovf(t2_ovf)
	);
	logic ext_prev;
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			half <= 1'b0;
			ext_prev <= 1'b1;
			ext_int2 <= 1'b0;
		end
		else
		begin
			half <= !half;
			ext_prev <= timer2_ext_pin;
			ext_int2 <= t2_run && ext_prev && !timer2_ext_pin;
		end
	end
	// ****************************************
	// transmitter
	// ****************************************
	uarx_tx_st_t tx_st;
	logic [3:0] tx_os, tx_idx;
	logic hold_valid, tx_write, tx_tick, tx_done, next_txd;
	logic [7:0] tx_hold;
	assign tx_write = wr_en && wa == `UX_OFS_BUF && ws[0];
	assign tx_tick = baud_tick(mode, t2_ctrl[`UX_B_TCLK], t2_ovf, timer1_ovf, half);
	assign tx_done = tx_st == UX_TX_SHIFT && tx_tick && tx_os == `UX_OS_LAST &&
		tx_idx == last_bit(mode);
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			tx_st <= UX_TX_IDLE;
			tx_os <= 4'h0;
			tx_idx <= 4'h0;
			hold_valid <= 1'b0;
			tx_hold <= `UX_RST8;
			tx_data <= `UX_RST8;
		end
		else
		begin
			if (tx_write)
			begin
				hold_valid <= 1'b1;
				tx_hold <= wd0;
			end
			if (tx_st == UX_TX_IDLE && hold_valid)
			begin
				tx_st <= UX_TX_SHIFT;
				tx_data <= tx_hold;
				hold_valid <= tx_write;
				tx_os <= 4'h0;
				tx_idx <= 4'h0;
			end
			else if (tx_st == UX_TX_SHIFT && tx_tick)
			begin
				tx_os <= tx_os + 4'h1;
				if (tx_done)
					tx_st <= UX_TX_IDLE;
				else if (tx_os == `UX_OS_LAST)
					tx_idx <= tx_idx + 4'h1;
			end
		end
	end
	// ****************************************
	// receiver
	// ****************************************
	uarx_rx_st_t rx_st;
	logic [3:0] rx_os, rx_idx, rx_pos;
	logic [8:0] rx_sh, next_rx_sh;
	logic rx_prev, all_zero, rx_tick, smp, rx_done, rx_ok, fe_set, br_set, oe_set;
	assign rx_tick = baud_tick(mode, t2_ctrl[`UX_B_RCLK], t2_ovf, timer1_ovf, half);
	// mode 0 samples as the shift clock rises, other modes at the bit centre
	assign smp = rx_st == UX_RX_FRAME && rx_tick &&
		rx_os == (mode == 2'h0 ? `UX_M0_SAMPLE : `UX_OS_CENTRE);
	assign rx_done = smp && rx_idx == last_bit(mode);
	assign rx_pos = mode == 2'h0 ? rx_idx : rx_idx - 4'h1;
	always_comb
	begin
		next_rx_sh = rx_sh;
		if (smp && rx_pos < 4'h9 && (mode == 2'h0 || rx_idx != 4'h0))
			next_rx_sh[rx_pos] = rxd_in;
	end
	always_comb
	begin
		case (mode)
			2'h0: rx_ok = 1'b1;
			2'h1: rx_ok = !sm2 || rxd_in;
			default: rx_ok = !sm2 || (next_rx_sh[8] &&
				addr_hit(next_rx_sh[7:0], slave_address, slave_address_mask));
		endcase
	end
	assign fe_set = rx_done && mode != 2'h0 && !rxd_in;
	assign br_set = fe_set && all_zero;
	assign oe_set = smp && ri &&
		rx_idx == (mode == 2'h0 ? `UX_OVR_M0 : `UX_OVR_M123);
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rx_st <= UX_RX_IDLE;
			rx_os <= 4'h0;
			rx_idx <= 4'h0;
			rx_sh <= 9'h000;
			rx_prev <= 1'b1;
			all_zero <= 1'b0;
		end
		else
		begin
			rx_prev <= rxd_in;
			rx_sh <= next_rx_sh;
			if (rx_st == UX_RX_IDLE)
			begin
				rx_os <= 4'h0;
				rx_idx <= 4'h0;
				all_zero <= 1'b1;
				if (ren && (mode == 2'h0 ? (!ri && tx_st == UX_TX_IDLE && !hold_valid)
					: (rx_prev && !rxd_in)))
					rx_st <= UX_RX_FRAME;
			end
			else if (rx_tick)
			begin
				rx_os <= rx_os + 4'h1;
				if (smp && rxd_in)
					all_zero <= 1'b0;
				// a start bit gone high at its centre was a glitch
				if (rx_done || (smp && mode != 2'h0 && rx_idx == 4'h0 && rxd_in))
					rx_st <= UX_RX_IDLE;
				else if (rx_os == `UX_OS_LAST)
					rx_idx <= rx_idx + 4'h1;
			end
		end
	end
	// ****************************************
	// control, status and interrupt requests
	// ****************************************
	logic rb8_load, ri_set, ti_set;
	assign ri_set = rx_done && rx_ok && !ri;
	assign rb8_load = ri_set && mode != 2'h0;
	assign ti_set = tx_done || (tx_write && tx_st == UX_TX_IDLE && !hold_valid);
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ser_ctrl <= `UX_RST8;
			ext_stat <= `UX_RST8;
			rx_buf <= `UX_RST8;
		end
		else
		begin
			if (sc_wr)
				ser_ctrl[7:3] <= wd0[7:3];
			// hardware set wins over a software clear in the same cycle
			ser_ctrl[`UX_B_RB8] <= rb8_load ? next_rx_sh[8] :
				(sc_wr ? wd0[`UX_B_RB8] : ser_ctrl[`UX_B_RB8]);
			ser_ctrl[`UX_B_TI] <= ti_set | (sc_wr ? wd0[`UX_B_TI] : ti);
			ser_ctrl[`UX_B_RI] <= ri_set | (sc_wr ? wd0[`UX_B_RI] : ri);
			if (ri_set)
				rx_buf <= next_rx_sh[7:0];
			ext_stat[`UX_B_FE] <= fe_set | (st_wr ? wd0[`UX_B_FE] : ext_stat[`UX_B_FE]);
			ext_stat[`UX_B_BR] <= br_set | (st_wr ? wd0[`UX_B_BR] : ext_stat[`UX_B_BR]);
			ext_stat[`UX_B_OE] <= oe_set | (st_wr ? wd0[`UX_B_OE] : ext_stat[`UX_B_OE]);
			if (st_wr)
				ext_stat[`UX_B_STINT] <= wd0[`UX_B_STINT];
		end
	end
	always_comb
	begin
		next_txd = 1'b1;
		if (mode == 2'h0)
			next_txd = tx_st == UX_TX_SHIFT ? tx_os[3] : (rx_st == UX_RX_FRAME ? rx_os[3] : 1'b1);
		else if (tx_st == UX_TX_SHIFT)
		begin
			if (tx_idx == 4'h0)
				next_txd = 1'b0;
			else if (tx_idx < 4'h9)
				next_txd = tx_data[3'(tx_idx - 4'h1)];
			else if (tx_idx == 4'h9 && mode != 2'h1)
				next_txd = ser_ctrl[`UX_B_TB8];
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			txd <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
			rx_irq <= 1'b0;
			tx_irq <= 1'b0;
		end
		else
		begin
			txd <= next_txd;
			rxd_oe <= mode == 2'h0 && tx_st == UX_TX_SHIFT;
			rxd_out <= tx_st == UX_TX_SHIFT ? tx_data[tx_idx[2:0]] : 1'b1;
			rx_irq <= ri | (stint & (|ext_stat[3:1]));
			tx_irq <= ti;
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	AST_FE_SET: assert property (fe_set |=> ext_stat[`UX_B_FE] [*2])
		else $error("framing flag not set or not held");
	AST_BRK_SET: assert property ($rose(ext_stat[`UX_B_BR]) |-> $past(br_set))
		else $error("break flag set without all-zero frame");
	AST_OVR_CAUSE: assert property ($rose(ext_stat[`UX_B_OE]) |-> $past(ri))
		else $error("overrun flag without pending receive flag");
	AST_IRQ_GATE: assert property (rx_irq |-> $past(ri || (stint && |ext_stat[3:1])))
		else $error("receive request without cause");
	AST_MPC_NINTH: assert property ((rx_done && mode[1] && sm2 && !next_rx_sh[8] && !ri &&
		!sc_wr) |=> !ri)
		else $error("data byte raised receive flag in multiprocessor mode");
	AST_M1_STOP: assert property ((rx_done && mode == 2'h1 && sm2 && !rxd_in && !ri &&
		!sc_wr) |=> !ri ##1 (!rx_irq || stint))
		else $error("mode 1 bad stop raised receive flag");
	AST_TX_NINTH: assert property ((tx_st == UX_TX_SHIFT && mode[1] && tx_idx == 4'h9)
		|=> txd == $past(ser_ctrl[`UX_B_TB8]))
		else $error("ninth transmit bit not from control field");
	AST_TI_END: assert property (tx_done |=> ti ##1 tx_irq)
		else $error("transmit flag missing at byte end");
	AST_EXT_INT2: assert property (ext_int2 |-> $past(t2_run))
		else $error("extra interrupt outside baud use");
	AST_REN_START: assert property ($rose(rx_st == UX_RX_FRAME) |-> $past(ren))
		else $error("reception started while disabled");
	COV_ADDR_MATCH: cover property (ri_set && mode == 2'h3 && sm2);
	COV_TX_BYTE: cover property (tx_done && hold_valid);
	COV_BREAK: cover property (br_set);
endmodule

// ---- testbench/uarx_node.sv ----
// remote serial node: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
module uarx_node (
	input wire logic clk,
	input wire logic txd,
	output logic line
);
	int bitclk = 32;
	int nbits = 9;
	int rx_count = 0;
	logic [9:0] got = 10'h000;
	initial line = 1'b1;
	// f[0] is the start bit, bits leave lsb first
	task automatic send(input logic [10:0] f, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			line <= f[i];
			repeat (bitclk - 1) @(posedge clk);
		end
		@(posedge clk);
		line <= 1'b1;
	endtask
	// centre sampling leaves half a bit of phase slack either way
	always
	begin
		@(negedge txd);
		repeat (bitclk / 2) @(posedge clk);
		if (txd === 1'b0)
		begin
			got = 10'h000;
			for (int i = 0; i < nbits; i++)
			begin
				repeat (bitclk) @(posedge clk);
				got[i] = txd;
			end
			rx_count++;
		end
	end
endmodule

// ---- testbench/uarx_top_tb.sv ----
// bench for the serial port: register bus tasks and serial scenarios
`timescale 1ns/1ps
`include "uarx_consts.svh"
module uarx_top_tb;
	import uarx_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic timer1_ovf = 1'b0;
	logic t2_pin = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, rxd_out, rxd_oe, txd;
	logic ext_int2, rx_irq, tx_irq, node_line, rxd_wire, seen;
	logic [1:0] bresp, rresp, wr_resp, rd_resp;
	logic [31:0] rdata, rd_data;
	logic [7:0] sh;
	logic [7:0] tbl [5] = '{8'hC0, 8'hC2, 8'hC1, 8'hFF, 8'h41};
	// given C0 with bit 1 ignored, broadcast needs ones on FD
	logic [7:0] exp_sc [5] = '{8'hB5, 8'hB5, 8'hB0, 8'hB5, 8'hB0};
	longint t0;
	int err_total = 0;
	int samples_checked = 0;
	// the receive line is shared: mode 0 transmit drives it from the block
	assign rxd_wire = rxd_oe ? rxd_out : node_line;
	always #2 clk = ~clk;
	// overflow every other clock gives 32 clocks per bit, same as mode 2
	always @(posedge clk) timer1_ovf <= ~timer1_ovf;
	uarx_top u_dut (
		.clk(clk),
		.rst_b(rst_b),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rxd_in(rxd_wire),
		.rxd_out(rxd_out),
		.rxd_oe(rxd_oe),
		.txd(txd),
		.timer1_ovf(timer1_ovf),
		.timer2_ext_pin(t2_pin),
		.ext_int2(ext_int2),
		.rx_irq(rx_irq),
		.tx_irq(tx_irq)
	);
	uarx_node u_node (
		.clk(clk),
		.txd(txd),
		.line(node_line)
	);
	// ************************************************************
	// tasks
	// ************************************************************
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	// readies are combinational: looking at the negedge shows what the next edge samples
	task automatic axi_write(input logic [11:0] a, input logic [31:0] v);
		logic ka, kw, ta, tw, tb;
		ta = 1'b0;
		tw = 1'b0;
		tb = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw))
		begin
			@(negedge clk);
			ka = awvalid && awready;
			kw = wvalid && wready;
			@(posedge clk);
			awvalid <= awvalid & ~ka;
			wvalid <= wvalid & ~kw;
			ta = ta | ka;
			tw = tw | kw;
		end
		while (!tb)
		begin
			@(negedge clk);
			tb = bvalid;
			wr_resp = bresp;
			@(posedge clk);
		end
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [11:0] a);
		logic ka, ta, tr;
		ta = 1'b0;
		tr = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ta)
		begin
			@(negedge clk);
			ka = arvalid && arready;
			@(posedge clk);
			arvalid <= arvalid & ~ka;
			ta = ka;
		end
		while (!tr)
		begin
			@(negedge clk);
			tr = rvalid;
			rd_data = rdata;
			rd_resp = rresp;
			@(posedge clk);
		end
		rready <= 1'b0;
	endtask
	task automatic wr8(input logic [11:0] a, input logic [7:0] v);
		axi_write(a, {24'h00_0000, v});
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		axi_read(a);
		chk(rd_data, {24'h00_0000, e});
		chk(32'(rd_resp), 32'(`UX_RESP_OK));
	endtask
	task automatic rx(input logic [7:0] b, input logic nin, input logic stp, input logic nine);
		if (nine)
			u_node.send({stp, nin, b, 1'b0}, 11);
		else
			u_node.send({1'b0, stp, b, 1'b0}, 10);
	endtask
	// write to the idle transmitter, then watch the frame on the line
	task automatic txf(input logic [7:0] b, input logic [7:0] m, input logic [9:0] e);
		int c;
		wr8(`UX_OFS_SCTL, m);
		c = u_node.rx_count;
		wr8(`UX_OFS_BUF, b);
		settle;
		chk(32'(tx_irq), 32'h0000_0001);
		wr8(`UX_OFS_SCTL, m);
		settle;
		chk(32'(tx_irq), 32'h0000_0000);
		chk(32'(rx_irq), 32'h0000_0000);
		for (int n = 0; n < 20000 && u_node.rx_count == c; n++)
			@(posedge clk);
		chk(32'(u_node.got), 32'(e));
		repeat (u_node.bitclk) @(posedge clk);
		settle;
		chk(32'(tx_irq), 32'h0000_0001);
	endtask
	task automatic pulse_seen;
		seen = 1'b0;
		repeat (8)
		begin
			@(negedge clk);
			seen = seen | ext_int2;
		end
	endtask
	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		repeat (40000) @(posedge clk);
		err_total++;
		finish_test;
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdc(`UX_OFS_SCTL, 8'h00);
		rdc(`UX_OFS_STAT, 8'h00);
		rdc(`UX_OFS_ADDR, 8'h00);
		rdc(`UX_OFS_MASK, 8'h00);
		axi_read(12'h500);
		chk(32'(rd_resp), 32'(`UX_RESP_ERR));
		axi_write(12'h500, 32'h0000_0001);
		chk(32'(wr_resp), 32'(`UX_RESP_ERR));
		$display("test registers done");
		txf(8'hA5, 8'h50, {2'b01, 8'hA5});
		u_node.nbits = 10;
		txf(8'h3C, 8'h90, {2'b10, 8'h3C});
		txf(8'hC3, 8'hD8, {2'b11, 8'hC3});
		$display("test transmit done");
		wr8(`UX_OFS_SCTL, 8'h50);
		rx(8'h3C, 1'b0, 1'b1, 1'b0);
		rdc(`UX_OFS_SCTL, 8'h55);
		rdc(`UX_OFS_BUF, 8'h3C);
		rx(8'h22, 1'b0, 1'b1, 1'b0);
		rdc(`UX_OFS_STAT, 8'h02);
		rdc(`UX_OFS_BUF, 8'h3C);
		wr8(`UX_OFS_SCTL, 8'h40);
		rx(8'h11, 1'b0, 1'b1, 1'b0);
		rdc(`UX_OFS_SCTL, 8'h40);
		$display("test receive done");
		wr8(`UX_OFS_STAT, 8'h00);
		wr8(`UX_OFS_SCTL, 8'h70);
		rx(8'h55, 1'b0, 1'b0, 1'b0);
		rdc(`UX_OFS_STAT, 8'h08);
		rdc(`UX_OFS_SCTL, 8'h70);
		settle;
		chk(32'(rx_irq), 32'h0000_0000);
		wr8(`UX_OFS_STAT, 8'h09);
		settle;
		chk(32'(rx_irq), 32'h0000_0001);
		rdc(`UX_OFS_STAT, 8'h09);
		wr8(`UX_OFS_STAT, 8'h00);
		rdc(`UX_OFS_STAT, 8'h00);
		rx(8'h00, 1'b0, 1'b0, 1'b0);
		rdc(`UX_OFS_STAT, 8'h0C);
		$display("test status done");
		wr8(`UX_OFS_STAT, 8'h00);
		wr8(`UX_OFS_SCTL, 8'hB0);
		rx(8'h77, 1'b1, 1'b1, 1'b1);
		rdc(`UX_OFS_SCTL, 8'hB5);
		wr8(`UX_OFS_SCTL, 8'hB0);
		rx(8'h77, 1'b0, 1'b1, 1'b1);
		rdc(`UX_OFS_SCTL, 8'hB0);
		wr8(`UX_OFS_ADDR, 8'hC0);
		wr8(`UX_OFS_MASK, 8'hFD);
		for (int i = 0; i < 5; i++)
		begin
			rx(tbl[i], 1'b1, 1'b1, 1'b1);
			rdc(`UX_OFS_SCTL, exp_sc[i]);
			wr8(`UX_OFS_SCTL, 8'hB0);
		end
		wr8(`UX_OFS_SCTL, 8'h90);
		rx(8'h12, 1'b0, 1'b1, 1'b1);
		rdc(`UX_OFS_SCTL, 8'h91);
		$display("test address match done");
		u_node.nbits = 9;
		axi_write(`UX_OFS_T2RLD, 32'h0000_FFFF);
		wr8(`UX_OFS_T2CTL, 8'h10);
		for (int p = 0; p < 2; p++)
		begin
			wr8(`UX_OFS_PRE, 8'(p * 4));
			u_node.bitclk = 64 << (2 * p);
			txf(8'h5A, 8'h50, {2'b01, 8'h5A});
		end
		@(posedge clk);
		t2_pin <= 1'b0;
		pulse_seen;
		chk(32'(seen), 32'h0000_0001);
		wr8(`UX_OFS_T2CTL, 8'h00);
		t2_pin <= 1'b1;
		repeat (4) @(posedge clk);
		t2_pin <= 1'b0;
		pulse_seen;
		chk(32'(seen), 32'h0000_0000);
		$display("test timer2 done");
		// mode 0 receive: data changes as the shift clock falls, sampled as it rises
		wr8(`UX_OFS_SCTL, 8'h30);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge txd);
			u_node.line <= tbl[4][i];
		end
		repeat (16) @(posedge clk);
		u_node.line <= 1'b1;
		rdc(`UX_OFS_BUF, 8'h41);
		rdc(`UX_OFS_SCTL, 8'h31);
		wr8(`UX_OFS_SCTL, 8'h00);
		wr8(`UX_OFS_BUF, 8'h96);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge txd);
			sh[i] = rxd_wire;
			if (i == 0)
				t0 = $time;
		end
		chk(32'(sh), 32'h0000_0096);
		chk(32'($time - t0), 32'h0000_01C0);
		chk(32'(rxd_oe), 32'h0000_0001);
		$display("test shift mode done");
		finish_test;
	end
endmodule
